// ### logic/asf_pkg.sv
/*
 * Constants shared by the ALU status flag block: opcode classes, flag bit
 * positions, update masks, register offsets and reset values.
 * Assumes a single core clock and that the decoder presents one operation
 * per cycle with its operands already fetched.
 */
package asf_pkg;

	localparam int unsigned DATA_W = 8;
	localparam int unsigned OP_W = 4;
	localparam int unsigned FLAG_W = 5;
	localparam int unsigned ADDR_W = 8;

	// operation classes presented by the instruction decoder
	localparam logic [3:0] OP_ADD_REG = 4'h0;
	localparam logic [3:0] OP_ADD_LIT = 4'h1;
	localparam logic [3:0] OP_SUB_LIT = 4'h2;
	localparam logic [3:0] OP_SUB_REG = 4'h3;
	localparam logic [3:0] OP_AND = 4'h4;
	localparam logic [3:0] OP_OR = 4'h5;
	localparam logic [3:0] OP_XOR = 4'h6;
	localparam logic [3:0] OP_COMP = 4'h7;
	localparam logic [3:0] OP_MOVE = 4'h8;
	localparam logic [3:0] OP_ROT_RIGHT = 4'h9;
	localparam logic [3:0] OP_ROT_LEFT = 4'hA;

	// status register bit positions
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_DC = 1;
	localparam int unsigned FLAG_Z = 2;
	localparam int unsigned FLAG_OV = 3;
	localparam int unsigned FLAG_N = 4;
	localparam int unsigned MSB = 7;
	localparam int unsigned NIB_MSB = 3;

	// rotate carry sources
	localparam int unsigned ROT_R_SRC = 4;
	localparam int unsigned ROT_L_SRC = 3;

	// which flags each class of operation writes
	localparam logic [4:0] UPD_ARITH = 5'h1F;
	localparam logic [4:0] UPD_LOGIC = 5'h14;
	localparam logic [4:0] UPD_ROT = 5'h15;
	localparam logic [4:0] UPD_NONE = 5'h00;

	// software view
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_RESULT = 8'h01;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;
	localparam logic [2:0] UNIMPL_BITS = 3'h0;

endpackage : asf_pkg

// ### logic/asf_alu_core.sv
/*
 * Combinational ALU core: computes the result, the five candidate flags and
 * the mask of flags that the operation is allowed to write.
 * Assumes operands are stable for the cycle in which they are presented.
 */
module asf_alu_core (
	input wire logic [3:0] op_i,
	input wire logic [7:0] opa_i,
	input wire logic [7:0] opb_i,
	input wire logic carry_i,
	output logic [7:0] result_o,
	output logic [4:0] flags_o,
	output logic [4:0] upd_mask_o,
	output logic legal_o
);

	// one nibble of the adder, chained twice for the full byte
	function automatic logic [4:0] add_nib(input logic [3:0] a, input logic [3:0] b, input logic ci);
		add_nib = {1'h0, a} + {1'h0, b} + {4'h0, ci};
	endfunction : add_nib

	wire logic is_add = (op_i == asf_pkg::OP_ADD_REG) || (op_i == asf_pkg::OP_ADD_LIT);
	wire logic is_sub = (op_i == asf_pkg::OP_SUB_REG) || (op_i == asf_pkg::OP_SUB_LIT);
	wire logic is_arith = is_add || is_sub;
	wire logic is_rot_r = (op_i == asf_pkg::OP_ROT_RIGHT);
	wire logic is_rot_l = (op_i == asf_pkg::OP_ROT_LEFT);
	wire logic is_logic = (op_i >= asf_pkg::OP_AND) && (op_i <= asf_pkg::OP_MOVE);

	// subtract as add of the complement plus one
	wire logic [7:0] b_eff = is_sub ? ~opb_i : opb_i;
	wire logic [4:0] lo_sum = add_nib(opa_i[3:0], b_eff[3:0], is_sub);
	wire logic [4:0] hi_sum = add_nib(opa_i[7:4], b_eff[7:4], lo_sum[4]);
	wire logic [7:0] sum = {hi_sum[3:0], lo_sum[3:0]};

	wire logic [7:0] rot_r = {carry_i, opa_i[7:1]};
	wire logic [7:0] rot_l = {opa_i[6:0], carry_i};

	assign result_o = is_arith ? sum :
		(op_i == asf_pkg::OP_AND) ? (opa_i & opb_i) :
		(op_i == asf_pkg::OP_OR) ? (opa_i | opb_i) :
		(op_i == asf_pkg::OP_XOR) ? (opa_i ^ opb_i) :
		(op_i == asf_pkg::OP_COMP) ? ~opa_i :
		is_rot_r ? rot_r :
		is_rot_l ? rot_l : opa_i;

	assign flags_o[asf_pkg::FLAG_N] = result_o[asf_pkg::MSB];
	// sign change is wrong only when both addends share a sign the sum lacks
	assign flags_o[asf_pkg::FLAG_OV] = (opa_i[asf_pkg::MSB] == b_eff[asf_pkg::MSB])
		&& (sum[asf_pkg::MSB] != opa_i[asf_pkg::MSB]);
	assign flags_o[asf_pkg::FLAG_Z] = (result_o == 8'h00);
	assign flags_o[asf_pkg::FLAG_DC] = lo_sum[4];
	assign flags_o[asf_pkg::FLAG_C] = is_arith ? hi_sum[4] :
		is_rot_r ? opa_i[asf_pkg::ROT_R_SRC] : opa_i[asf_pkg::ROT_L_SRC];

	assign upd_mask_o = is_arith ? asf_pkg::UPD_ARITH :
		(is_rot_r || is_rot_l) ? asf_pkg::UPD_ROT :
		is_logic ? asf_pkg::UPD_LOGIC : asf_pkg::UPD_NONE;
	assign legal_o = is_arith || is_rot_r || is_rot_l || is_logic;

endmodule : asf_alu_core

// ### logic/asf_status_flags.sv
/*
 * Top of the ALU status flag block: holds the status and last result
 * registers, merges decoder updates with software writes and answers the
 * register port.
 * Assumes the decoder raises exec_i for one cycle per operation and that
 * software strobes are one cycle long and never both high at once.
 */
module asf_status_flags (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic exec_i,
	input wire logic [3:0] op_i,
	input wire logic [7:0] opa_i,
	input wire logic [7:0] opb_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic [7:0] status_o,
	output logic [7:0] result_o,
	output logic done_o
);

	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] result_q;
	logic [7:0] result_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic done_q;
	logic done_d;

	logic [7:0] core_result;
	logic [4:0] core_flags;
	logic [4:0] core_mask;
	logic core_legal;

	// rotates shift in the carry as it stands before this operation
	asf_alu_core u_core (
		.op_i(op_i),
		.opa_i(opa_i),
		.opb_i(opb_i),
		.carry_i(status_q[asf_pkg::FLAG_C]),
		.result_o(core_result),
		.flags_o(core_flags),
		.upd_mask_o(core_mask),
		.legal_o(core_legal)
	);

	// unknown opcodes are dropped: no flag, no result, no done
	wire logic hw_upd = exec_i && core_legal;
	wire logic sel_status = (reg_addr_i == asf_pkg::REG_STATUS);
	wire logic sel_result = (reg_addr_i == asf_pkg::REG_RESULT);
	wire logic sw_wr = reg_wr_i && sel_status;

	// a flag the ALU writes in the same cycle as software takes the ALU value
	wire logic [4:0] hw_sel = {asf_pkg::FLAG_W{hw_upd}} & core_mask;
	wire logic [4:0] sw_sel = {asf_pkg::FLAG_W{sw_wr}} & ~hw_sel;
	wire logic [4:0] keep_sel = ~(hw_sel | sw_sel);
	wire logic [4:0] flags_next = (hw_sel & core_flags)
		| (sw_sel & reg_wdata_i[4:0])
		| (keep_sel & status_q[4:0]);

	assign status_d = {asf_pkg::UNIMPL_BITS, flags_next};
	assign result_d = hw_upd ? core_result : result_q;
	assign done_d = hw_upd;

	// reads show the state before any update taken in the same cycle
	wire logic [7:0] rd_mux = sel_status ? status_q :
		sel_result ? result_q : asf_pkg::RDATA_IDLE;
	assign rdata_d = reg_rd_i ? rd_mux : asf_pkg::RDATA_IDLE;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			status_q <= asf_pkg::STATUS_RST;
			result_q <= asf_pkg::RESULT_RST;
		end else begin
			status_q <= status_d;
			result_q <= result_d;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rdata_q <= asf_pkg::RDATA_IDLE;
			done_q <= 1'h0;
		end else begin
			rdata_q <= rdata_d;
			done_q <= done_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign status_o = status_q;
	assign result_o = result_q;
	assign done_o = done_q;

	// independent reference for the checks below; kept apart from the core
	wire logic chk_add = exec_i && ((op_i == asf_pkg::OP_ADD_REG) || (op_i == asf_pkg::OP_ADD_LIT));
	wire logic chk_sub = exec_i && ((op_i == asf_pkg::OP_SUB_REG) || (op_i == asf_pkg::OP_SUB_LIT));
	wire logic chk_arith = chk_add || chk_sub;
	wire logic [7:0] chk_b = chk_sub ? ~opb_i : opb_i;
	wire logic [8:0] chk_sum9 = {1'h0, opa_i} + {1'h0, chk_b} + {8'h00, chk_sub};
	wire logic [4:0] chk_nib5 = {1'h0, opa_i[3:0]} + {1'h0, chk_b[3:0]} + {4'h0, chk_sub};
	wire logic chk_ov = (opa_i[7] == chk_b[7]) && (chk_sum9[7] != opa_i[7]);
	wire logic [8:0] chk_diff9 = {1'h0, opa_i} - {1'h0, opb_i};
	wire logic chk_rot_r = exec_i && (op_i == asf_pkg::OP_ROT_RIGHT);
	wire logic chk_rot_l = exec_i && (op_i == asf_pkg::OP_ROT_LEFT);
	wire logic chk_logic = exec_i && (op_i >= asf_pkg::OP_AND) && (op_i <= asf_pkg::OP_MOVE);
	wire logic chk_any = chk_arith || chk_rot_r || chk_rot_l || chk_logic;
	wire logic chk_and = exec_i && (op_i == asf_pkg::OP_AND);
	wire logic chk_comp = exec_i && (op_i == asf_pkg::OP_COMP);
	wire logic chk_illegal = exec_i && !chk_any;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence arith_s;
		chk_arith;
	endsequence

	sequence sub_s;
		chk_sub;
	endsequence

	// software plants a carry, then a rotate right pulls it into bit 7
	sequence carry_then_rot_s;
		(sw_wr && !exec_i) ##1 chk_rot_r;
	endsequence

	// a flag-writing op followed by an idle cycle must leave flags alone
	sequence op_then_idle_s;
		chk_any ##1 (!exec_i && !reg_wr_i);
	endsequence

	property flag_tracks_p(int unsigned pos, logic expect_v);
		arith_s |=> status_q[pos] == $past(expect_v);
	endproperty

	neg_flag_a: assert property (
		chk_any |=> status_q[asf_pkg::FLAG_N] == result_q[7]
	) else $error("negative flag differs from result bit 7");

	neg_hold_a: assert property (
		op_then_idle_s |=> status_q[asf_pkg::FLAG_N] == $past(status_q[asf_pkg::FLAG_N])
	) else $error("negative flag moved with no operation");

	ovf_flag_a: assert property (
		flag_tracks_p(asf_pkg::FLAG_OV, chk_ov)
	) else $error("overflow flag wrong after add or subtract");

	ovf_logic_a: assert property (
		(chk_logic && !sw_wr) |=> $stable(status_q[asf_pkg::FLAG_OV])
	) else $error("logic operation disturbed overflow flag");

	zero_flag_a: assert property (
		chk_any |=> status_q[asf_pkg::FLAG_Z] == (result_q == 8'h00)
	) else $error("zero flag does not match result");

	zero_bit_pos_a: assert property (
		(chk_logic && opa_i == 8'h00 && op_i == asf_pkg::OP_MOVE) |=> status_o[2]
	) else $error("zero result did not set status bit 2");

	nib_carry_a: assert property (
		flag_tracks_p(asf_pkg::FLAG_DC, chk_nib5[4])
	) else $error("nibble carry flag wrong");

	carry_out_a: assert property (
		flag_tracks_p(asf_pkg::FLAG_C, chk_sum9[8])
	) else $error("carry flag wrong after add or subtract");

	add_result_a: assert property (
		chk_add |=> (result_q == $past(chk_sum9[7:0])) && done_o
	) else $error("add result wrong");

	sub_borrow_a: assert property (
		sub_s |=> status_q[asf_pkg::FLAG_C] == $past(opa_i >= opb_i)
	) else $error("carry is not the inverted borrow after subtract");

	sub_result_a: assert property (
		sub_s |=> result_q == $past(chk_diff9[7:0])
	) else $error("subtract result wrong");

	rot_right_a: assert property (
		chk_rot_r |=> status_q[asf_pkg::FLAG_C] == $past(opa_i[4])
	) else $error("rotate right loaded carry from wrong bit");

	rot_left_a: assert property (
		chk_rot_l |=> status_q[asf_pkg::FLAG_C] == $past(opa_i[3])
	) else $error("rotate left loaded carry from wrong bit");

	rot_carry_in_a: assert property (
		carry_then_rot_s |=> result_q[7] == $past(reg_wdata_i[asf_pkg::FLAG_C], 2)
	) else $error("rotate did not shift in the stored carry");

	done_pulse_a: assert property (
		chk_any |=> done_o ##1 (done_o == $past(chk_any))
	) else $error("done pulse does not follow an operation");

	read_latency_a: assert property (
		(reg_rd_i && sel_status) |=> reg_rdata_o == $past(status_q)
	) else $error("status read data late or wrong");

	read_idle_a: assert property (
		!reg_rd_i |=> reg_rdata_o == 8'h00
	) else $error("read data not idle without a read");

	unimpl_zero_a: assert property (
		status_o[7:5] == 3'h0
	) else $error("unimplemented status bits not zero");

	sw_write_a: assert property (
		(sw_wr && !exec_i) |=> status_q[4:0] == $past(reg_wdata_i[4:0])
	) else $error("software write to status not taken");

	hw_wins_a: assert property (
		(sw_wr && chk_arith) |=> status_q[4:0] == $past(core_flags)
	) else $error("software write beat a same-cycle flag update");

	// second opinion on the flags, written from operand properties rather than from the adder
	and_flags_a: assert property (
		chk_and |=> (status_q[asf_pkg::FLAG_N] == $past(opa_i[7] & opb_i[7])) && (status_q[asf_pkg::FLAG_Z] == $past((opa_i & opb_i) == 8'h00))
	) else $error("and operation gave wrong negative or zero flag");

	comp_neg_a: assert property (
		chk_comp |=> status_q[asf_pkg::FLAG_N] == !$past(opa_i[7])
	) else $error("complement gave wrong negative flag");

	ovf_pos_a: assert property (
		(chk_add && !opa_i[7] && !opb_i[7]) |=> status_q[asf_pkg::FLAG_OV] == $past(chk_sum9[7])
	) else $error("overflow wrong for two positive addends");

	ovf_neg_a: assert property (
		(chk_add && opa_i[7] && opb_i[7]) |=> status_q[asf_pkg::FLAG_OV] == !$past(chk_sum9[7])
	) else $error("overflow wrong for two negative addends");

	ovf_mixed_a: assert property (
		(chk_add && (opa_i[7] != opb_i[7])) |=> !status_q[asf_pkg::FLAG_OV]
	) else $error("overflow set for addends of mixed sign");

	sub_equal_a: assert property (
		(chk_sub && (opa_i == opb_i)) |=> status_q[asf_pkg::FLAG_Z] && status_q[asf_pkg::FLAG_C]
	) else $error("equal subtract did not give zero with no borrow");

	add_carries_a: assert property (
		chk_add |=> (status_q[asf_pkg::FLAG_C] == $past(opa_i > ~opb_i)) && (status_q[asf_pkg::FLAG_DC] == $past(opa_i[3:0] > ~opb_i[3:0]))
	) else $error("add carries wrong");

	sub_nib_borrow_a: assert property (
		sub_s |=> status_q[asf_pkg::FLAG_DC] == $past(opa_i[3:0] >= opb_i[3:0])
	) else $error("nibble carry is not the inverted nibble borrow");

	rot_right_res_a: assert property (
		chk_rot_r |=> result_q == {$past(status_q[asf_pkg::FLAG_C]), $past(opa_i[7:1])}
	) else $error("rotate right result wrong");

	rot_left_res_a: assert property (
		chk_rot_l |=> result_q == {$past(opa_i[6:0]), $past(status_q[asf_pkg::FLAG_C])}
	) else $error("rotate left result wrong");

	rot_keep_a: assert property (
		((chk_rot_r || chk_rot_l) && !sw_wr) |=> $stable(status_q[asf_pkg::FLAG_OV]) && $stable(status_q[asf_pkg::FLAG_DC])
	) else $error("rotate disturbed overflow or nibble carry");

	logic_keep_a: assert property (
		(chk_logic && !sw_wr) |=> $stable(status_q[asf_pkg::FLAG_C]) && $stable(status_q[asf_pkg::FLAG_DC])
	) else $error("logic operation disturbed a carry flag");

	illegal_drop_a: assert property (
		(chk_illegal && !reg_wr_i) |=> $stable(status_q) && $stable(result_q) && !done_o
	) else $error("unknown opcode changed state");

	idle_hold_a: assert property (
		(!exec_i && !reg_wr_i) |=> $stable(status_q) && $stable(result_q)
	) else $error("state moved with no request");

	result_read_a: assert property (
		(reg_rd_i && sel_result) |=> reg_rdata_o == $past(result_q)
	) else $error("result read data late or wrong");

	unmapped_read_a: assert property (
		(reg_rd_i && !sel_status && !sel_result) |=> reg_rdata_o == asf_pkg::RDATA_IDLE
	) else $error("unmapped read returned data");

	wr_other_a: assert property (
		(reg_wr_i && !sel_status && !exec_i) |=> $stable(status_q)
	) else $error("write to another address changed status");

	done_legal_a: assert property (
		done_o |-> $past(chk_any)
	) else $error("done pulse without a legal operation");

	move_result_a: assert property (
		(exec_i && (op_i == asf_pkg::OP_MOVE)) |=> result_q == $past(opa_i)
	) else $error("move result wrong");

	xor_result_a: assert property (
		(exec_i && (op_i == asf_pkg::OP_XOR)) |=> result_q == $past(opa_i ^ opb_i)
	) else $error("xor result wrong");

	or_result_a: assert property (
		(exec_i && (op_i == asf_pkg::OP_OR)) |=> result_q == $past(opa_i | opb_i)
	) else $error("or result wrong");

endmodule : asf_status_flags

// ### verif/asf_dec_model.sv
/*
 * Behavioural model of the instruction decoder and operand path that feeds the
 * status flag block: presents one operation per call, back to back if asked.
 * Assumes the bench calls issue at most once per clock and idle to stop.
 */
module asf_dec_model (
	input wire logic clock_i,
	output logic exec_o,
	output logic [3:0] op_o,
	output logic [7:0] opa_o,
	output logic [7:0] opb_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		exec_o = 1'b0;
		op_o = 4'h0;
		opa_o = 8'h00;
		opb_o = 8'h00;
	end

	task automatic issue(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
		@(posedge clock_i);
		exec_o <= 1'b1;
		op_o <= op;
		opa_o <= a;
		opb_o <= b;
	endtask : issue

	// operands are scrambled once released so stale values cannot pass for live ones
	task automatic idle();
		@(posedge clock_i);
		exec_o <= 1'b0;
		opa_o <= ~opa_o;
		opb_o <= ~opb_o;
	endtask : idle

endmodule : asf_dec_model

// ### verif/tb_top.sv
/*
 * Self-checking bench for the status flag block: directed corners, rotates,
 * refused opcodes, random traffic and the software register port.
 * Assumes one clock and the one-cycle answer timing of the block.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock_i, sys_rst_i, exec, reg_wr, reg_rd, done, rd_d;
	logic [3:0] op;
	logic [7:0] opa, opb, reg_addr, reg_wdata, reg_rdata, status, result, lr;
	logic [4:0] st;
	logic [15:0] e;
	logic [31:0] rng;
	logic [15:0] opq[$];
	logic [7:0] rdq[$];
	int fails, n_compared, cycles;

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	asf_dec_model i_dec (.clock_i(clock_i), .exec_o(exec), .op_o(op), .opa_o(opa), .opb_o(opb));

	asf_status_flags i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .exec_i(exec), .op_i(op), .opa_i(opa),
		.opb_i(opb), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .status_o(status), .result_o(result), .done_o(done));

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xs

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic end_test(input string name);
		$display("test %s done, %0d compared, %0d failing", name, n_compared, fails);
	endtask : end_test

	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// expectation is noted before the request so the monitor can never outrun it
	task automatic op_go(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		logic [4:0] nib;
		logic [7:0] bb;
		logic [7:0] r;
		bb = o[1] ? ~b : b;
		s = {1'b0, a} + {1'b0, bb} + {8'h00, o[1]};
		nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, o[1]};
		r = s[7:0];
		case (o)
			4'h0, 4'h1, 4'h2, 4'h3: begin
				st[asf_pkg::FLAG_C] = s[8];
				st[asf_pkg::FLAG_DC] = nib[4];
				st[asf_pkg::FLAG_OV] = (a[7] == bb[7]) && (r[7] != a[7]);
			end
			4'h4: r = a & b;
			4'h5: r = a | b;
			4'h6: r = a ^ b;
			4'h7: r = ~a;
			4'h8: r = a;
			4'h9: begin
				r = {st[asf_pkg::FLAG_C], a[7:1]};
				st[asf_pkg::FLAG_C] = a[asf_pkg::ROT_R_SRC];
			end
			4'hA: begin
				r = {a[6:0], st[asf_pkg::FLAG_C]};
				st[asf_pkg::FLAG_C] = a[asf_pkg::ROT_L_SRC];
			end
			default: ;
		endcase
		if (o <= 4'hA) begin
			st[asf_pkg::FLAG_N] = r[7];
			st[asf_pkg::FLAG_Z] = (r == 8'h00);
			lr = r;
			opq.push_back({r, 3'b000, st});
		end
		i_dec.issue(o, a, b);
	endtask : op_go

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		// model takes the value at the call so a same-cycle operation noted later can override it
		if (a == asf_pkg::REG_STATUS) st = d[4:0];
		@(posedge clock_i);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock_i);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
		rdq.push_back(exp);
		@(posedge clock_i);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock_i);
		reg_rd <= 1'b0;
	endtask : reg_read

	always @(posedge clock_i) begin
		rd_d <= reg_rd & ~sys_rst_i;
		if (done === 1'b1) begin
			e = (opq.size() != 0) ? opq.pop_front() : 16'hXXXX;
			check(result, e[15:8], "result");
			check(status, e[7:0], "status");
		end
		if (rd_d) begin
			check(reg_rdata, rdq.pop_front(), "read data");
		end else if (!sys_rst_i) begin
			check(reg_rdata, 8'h00, "idle read data");
		end
	end

	// about 460 cycles are needed; the ceiling leaves ample margin
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			fails++;
			$display("MISMATCH at %0t: run did not complete", $time);
			finish_test();
		end
	end

	initial begin
		sys_rst_i = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		rd_d = 1'b0;
		st = 5'h00;
		lr = 8'h00;
		rng = 32'hB248;
		fails = 0;
		n_compared = 0;
		cycles = 0;
		repeat (4) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		reg_read(asf_pkg::REG_STATUS, 8'h00);
		reg_read(asf_pkg::REG_RESULT, 8'h00);
		end_test("reset");
		op_go(4'h0, 8'h7F, 8'h01);
		op_go(4'h0, 8'hFF, 8'h01);
		op_go(4'h2, 8'h05, 8'h05);
		op_go(4'h3, 8'h00, 8'h01);
		op_go(4'h3, 8'h80, 8'h01);
		op_go(4'h1, 8'h80, 8'h80);
		op_go(4'h2, 8'h10, 8'h01);
		i_dec.idle();
		reg_read(asf_pkg::REG_STATUS, {3'b000, st});
		end_test("corners");
		for (int c = 0; c < 2; c++) begin
			// the rotate follows the carry write with no gap, so the stored carry is shifted in
			fork
				reg_write(asf_pkg::REG_STATUS, {7'h00, c[0]});
				begin
					@(posedge clock_i);
					op_go(4'h9, 8'h11, 8'h00);
				end
			join
			op_go(4'hA, 8'h08, 8'h00);
			op_go(4'h9, 8'hEF, 8'h00);
			op_go(4'hA, 8'hF7, 8'h00);
			i_dec.idle();
		end
		end_test("rotates");
		for (int i = 11; i < 16; i++) op_go(i[3:0], 8'h00, 8'h00);
		op_go(4'h8, 8'h00, 8'h00);
		i_dec.idle();
		end_test("refused codes");
		repeat (400) begin
			void'(xs());
			op_go(rng[3:0], rng[15:8], rng[23:16]);
		end
		i_dec.idle();
		reg_read(asf_pkg::REG_STATUS, {3'b000, st});
		end_test("random");
		// software write and an add in one cycle: the add owns all five flags
		fork
			reg_write(asf_pkg::REG_STATUS, 8'h1F);
			begin
				@(negedge clock_i);
				op_go(4'h0, 8'h01, 8'h01);
				i_dec.idle();
			end
		join
		reg_read(asf_pkg::REG_STATUS, {3'b000, st});
		reg_write(asf_pkg::REG_STATUS, 8'hFF);
		reg_read(asf_pkg::REG_STATUS, 8'h1F);
		reg_write(asf_pkg::REG_RESULT, 8'h5A);
		reg_read(asf_pkg::REG_RESULT, lr);
		reg_read(8'h02, 8'h00);
		reg_write(asf_pkg::REG_STATUS, 8'hE0);
		reg_read(asf_pkg::REG_STATUS, 8'h00);
		repeat (4) @(posedge clock_i);
		check(8'(opq.size()), 8'h00, "answers missing");
		end_test("registers");
		finish_test();
	end

endmodule : tb_top
